/* design/ckss_pkg.sv */
package ckss_pkg;
   // Register byte offsets on the Wishbone slave.
   localparam logic [3:0] OFS_FUSE = 4'h0;
   localparam logic [3:0] OFS_TRIM = 4'h4;
   localparam logic [3:0] OFS_CTRL = 4'h8;
   localparam logic [3:0] OFS_STAT = 4'hC;

   // Fuse register layout.
   localparam int FUSE_W = 7;
   localparam int FUSE_SRC_LSB = 0;
   localparam int FUSE_STRT_LSB = 4;
   localparam int FUSE_DIV8_BIT = 6;
   localparam logic [FUSE_W-1:0] FUSE_RST = 7'h62;

   // Control register: writing one here enters power-down.
   localparam int CTRL_SLEEP_BIT = 0;

   // Status register layout.
   localparam int STAT_CFG_LSB = 0;
   localparam int STAT_RUN_BIT = 7;
   localparam int STAT_FAULT_BIT = 8;
   localparam int STAT_SLEEP_BIT = 9;

   // Source select codes.
   localparam logic [3:0] SRC_RC = 4'h2;
   localparam logic [3:0] SRC_LP = 4'h3;
   localparam logic [2:0] SRC_LF_PREFIX = 3'h2;

   // Start-up time codes.
   localparam logic [1:0] STRT_NONE = 2'h0;
   localparam logic [1:0] STRT_SHORT = 2'h1;
   localparam logic [1:0] STRT_LONG = 2'h2;
   localparam logic [1:0] STRT_RSVD = 2'h3;

   // Sampled pin indices.
   localparam int PIN_LF = 0;
   localparam int PIN_RC = 1;
   localparam int PIN_LP = 2;
   localparam int PIN_WDT = 3;
   localparam int PIN_WAKE = 4;
   localparam int PIN_N = 5;

   // Start-up counts in cycles of the selected oscillator.
   localparam int CNT_W = 24;
   localparam int RST_CK = 14;
   localparam int WAKE_LF0_CK = 1024;
   localparam int WAKE_LF1_CK = 32768;
   localparam int WAKE_INT_CK = 6;

   // Reset time-out extensions, timed by the watchdog oscillator.
   localparam int WDT_OSC_KHZ = 128;
   localparam int T_RC_SHORT_US = 4100;
   localparam int T_RC_LONG_US = 65000;
   localparam int T_LP_SHORT_US = 4000;
   localparam int T_LP_LONG_US = 64000;
   localparam int TOUT_RC_SHORT = (T_RC_SHORT_US * WDT_OSC_KHZ + 999) / 1000;
   localparam int TOUT_RC_LONG = (T_RC_LONG_US * WDT_OSC_KHZ + 999) / 1000;
   localparam int TOUT_LP_SHORT = (T_LP_SHORT_US * WDT_OSC_KHZ + 999) / 1000;
   localparam int TOUT_LP_LONG = (T_LP_LONG_US * WDT_OSC_KHZ + 999) / 1000;

   // Output clock divider.
   localparam int DIV_CNT_W = 2;
   localparam logic [DIV_CNT_W-1:0] DIV_LAST = 2'h3;

   typedef enum logic [2:0] {
      ST_TOUT_CK,
      ST_TOUT_MS,
      ST_RUN,
      ST_SLEEP,
      ST_WAKE,
      ST_FAULT
   } ckss_state_t;
endpackage

/* design/ckss_pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module ckss_pin_sync (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic pin_i,
   output logic lvl_o,
   output logic rise_o
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic lvl_r;
   logic lvl_nxt;
   logic rise_r;
   logic rise_nxt;

   // A change is accepted only once the second and third stages agree.
   always_comb begin
      lvl_nxt = lvl_r;
      rise_nxt = 1'b0;
      if (s2_r == s3_r) begin
         lvl_nxt = s3_r;
         rise_nxt = s3_r & ~lvl_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         lvl_r <= 1'b0;
         rise_r <= 1'b0;
      end else begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         lvl_r <= lvl_nxt;
         rise_r <= rise_nxt;
      end
   end

   assign lvl_o = lvl_r;
   assign rise_o = rise_r;
endmodule
`default_nettype wire

/* design/ckss_clk_gen.sv */
`timescale 1ns/100ps
`default_nettype none
module ckss_clk_gen (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic run_i,
   input wire logic div8_i,
   input wire logic src_lvl_i,
   input wire logic src_rise_i,
   output logic clk_o
);
   logic [ckss_pkg::DIV_CNT_W-1:0] cnt_r;
   logic [ckss_pkg::DIV_CNT_W-1:0] cnt_nxt;
   logic clk_r;
   logic clk_nxt;

   // Gating forces the output low at once, so a high phase in progress when the clock stops is cut short.
   always_comb begin
      cnt_nxt = cnt_r;
      clk_nxt = 1'b0;
      if (run_i) begin
         if (div8_i) begin
            clk_nxt = clk_r;
            if (src_rise_i) begin
               cnt_nxt = cnt_r + 1'b1;
               if (cnt_r == ckss_pkg::DIV_LAST) begin
                  clk_nxt = ~clk_r;
               end
            end
         end else begin
            clk_nxt = src_lvl_i;
         end
      end else begin
         cnt_nxt = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cnt_r <= '0;
         clk_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         clk_r <= clk_nxt;
      end
   end

   assign clk_o = clk_r;
endmodule
`default_nettype wire

/* design/ckss_top.sv */
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Crystal with bit zero clear: wake 1K CK, reset 14CK + 0, 4.1 or 65 ms.
// - Crystal with bit zero set: wake 32K CK, reset delays as for bit clear.
// - Source field 0010 selects the calibrated internal RC oscillator.
// - RC oscillator waits 6 CK on wake; reset adds 14CK + 0, 4.1 or 65ms.
// - Reset leaves RC source, start-up code 10 and divide-by-eight set.
// - Every reset copies the factory trim value into the RC trim register.
// - The watchdog oscillator times the reset time-out whatever the source.
// - Source field 0011 selects the 128kHz internal oscillator.
// - 128kHz oscillator waits 6 CK on wake; reset adds 14CK + 0, 4 or 64ms.
// - With divide-by-eight programmed the selected clock is divided by 8.
module ckss_top #(
   parameter int WAKE_LF1_CK = ckss_pkg::WAKE_LF1_CK,
   parameter int TOUT_RC_SHORT = ckss_pkg::TOUT_RC_SHORT,
   parameter int TOUT_RC_LONG = ckss_pkg::TOUT_RC_LONG,
   parameter int TOUT_LP_SHORT = ckss_pkg::TOUT_LP_SHORT,
   parameter int TOUT_LP_LONG = ckss_pkg::TOUT_LP_LONG
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [7:0] factory_trim_i,
   input wire logic lf_osc_i,
   input wire logic rc_osc_i,
   input wire logic lp_osc_i,
   input wire logic wdt_osc_i,
   input wire logic wake_i,
   output logic [7:0] rc_trim_o,
   output logic lf_osc_en_o,
   output logic rc_osc_en_o,
   output logic lp_osc_en_o,
   output logic wdt_tick_o,
   output logic sys_clk_run_o,
   output logic sys_clk_o
);
   localparam int FW = ckss_pkg::FUSE_W;
   localparam int CW = ckss_pkg::CNT_W;

   logic [ckss_pkg::PIN_N-1:0] pins;
   logic [ckss_pkg::PIN_N-1:0] lvl;
   logic [ckss_pkg::PIN_N-1:0] rise;

   ckss_pkg::ckss_state_t state_r;
   ckss_pkg::ckss_state_t state_nxt;
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic [FW-1:0] cfg_r;
   logic [FW-1:0] cfg_nxt;
   logic [FW-1:0] fuse_r;
   logic [FW-1:0] fuse_nxt;
   logic [7:0] trim_r;
   logic [7:0] trim_nxt;
   logic ack_r;
   logic ack_nxt;
   logic [31:0] rdat_r;
   logic [31:0] rdat_nxt;
   logic tick_r;
   logic [2:0] en_r;
   logic [2:0] en_nxt;

   logic wb_req;
   logic wr_fuse;
   logic wr_trim;
   logic wr_sleep;
   logic [3:0] cfg_src;
   logic [1:0] cfg_strt;
   logic cfg_is_lf;
   logic cfg_is_rc;
   logic cfg_is_lp;
   logic cfg_bad;
   logic src_lvl;
   logic src_rise;
   logic [CW-1:0] wake_tgt;
   logic [CW-1:0] tout_tgt;
   logic running;

   assign pins = {wake_i, wdt_osc_i, lp_osc_i, rc_osc_i, lf_osc_i};

   genvar gi;
   generate
      for (gi = 0; gi < ckss_pkg::PIN_N; gi++) begin : g_pin
         ckss_pin_sync u_sync (
            .clk_i(clk_i),
            .sys_rst_i(sys_rst_i),
            .pin_i(pins[gi]),
            .lvl_o(lvl[gi]),
            .rise_o(rise[gi])
         );
      end
   endgenerate

   // Active configuration decode.
   assign cfg_src = cfg_r[ckss_pkg::FUSE_SRC_LSB +: 4];
   assign cfg_strt = cfg_r[ckss_pkg::FUSE_STRT_LSB +: 2];
   assign cfg_is_lf = (cfg_src[3:1] == ckss_pkg::SRC_LF_PREFIX);
   assign cfg_is_rc = (cfg_src == ckss_pkg::SRC_RC);
   assign cfg_is_lp = (cfg_src == ckss_pkg::SRC_LP);
   // Unsupported sources and the reserved start-up code stop the clock.
   assign cfg_bad = ~(cfg_is_lf | cfg_is_rc | cfg_is_lp) |
                    (cfg_strt == ckss_pkg::STRT_RSVD);

   always_comb begin
      src_lvl = 1'b0;
      src_rise = 1'b0;
      if (cfg_is_lf) begin
         src_lvl = lvl[ckss_pkg::PIN_LF];
         src_rise = rise[ckss_pkg::PIN_LF];
      end else if (cfg_is_rc) begin
         src_lvl = lvl[ckss_pkg::PIN_RC];
         src_rise = rise[ckss_pkg::PIN_RC];
      end else if (cfg_is_lp) begin
         src_lvl = lvl[ckss_pkg::PIN_LP];
         src_rise = rise[ckss_pkg::PIN_LP];
      end
   end

   // Wake-up delay in cycles of the newly selected oscillator.
   always_comb begin
      wake_tgt = CW'(ckss_pkg::WAKE_INT_CK);
      if (cfg_is_lf) begin
         if (cfg_src[0]) begin
            wake_tgt = CW'(WAKE_LF1_CK);
         end else begin
            wake_tgt = CW'(ckss_pkg::WAKE_LF0_CK);
         end
      end
   end

   // Reset time-out extension in watchdog oscillator edges.
   always_comb begin
      tout_tgt = CW'(TOUT_RC_LONG);
      if (cfg_is_lp) begin
         if (cfg_strt == ckss_pkg::STRT_SHORT) begin
            tout_tgt = CW'(TOUT_LP_SHORT);
         end else begin
            tout_tgt = CW'(TOUT_LP_LONG);
         end
      end else if (cfg_strt == ckss_pkg::STRT_SHORT) begin
         tout_tgt = CW'(TOUT_RC_SHORT);
      end
   end

   // Bus decode; the slave answers every access one cycle later.
   assign wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
   assign wr_fuse = wb_req & wb_we_i & wb_sel_i[0] &
                    (wb_adr_i == ckss_pkg::OFS_FUSE);
   assign wr_trim = wb_req & wb_we_i & wb_sel_i[0] &
                    (wb_adr_i == ckss_pkg::OFS_TRIM);
   assign wr_sleep = wb_req & wb_we_i & wb_sel_i[0] &
                     (wb_adr_i == ckss_pkg::OFS_CTRL) &
                     wb_dat_i[ckss_pkg::CTRL_SLEEP_BIT];

   assign running = (state_r == ckss_pkg::ST_RUN);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      cfg_nxt = cfg_r;
      case (state_r)
         ckss_pkg::ST_TOUT_CK: begin
            if (cfg_bad) begin
               state_nxt = ckss_pkg::ST_FAULT;
            end else if (src_rise) begin
               cnt_nxt = cnt_r + 1'b1;
               if (cnt_r == CW'(ckss_pkg::RST_CK - 1)) begin
                  cnt_nxt = '0;
                  if (cfg_strt == ckss_pkg::STRT_NONE) begin
                     state_nxt = ckss_pkg::ST_RUN;
                  end else begin
                     state_nxt = ckss_pkg::ST_TOUT_MS;
                  end
               end
            end
         end
         ckss_pkg::ST_TOUT_MS: begin
            if (rise[ckss_pkg::PIN_WDT]) begin
               cnt_nxt = cnt_r + 1'b1;
               if (cnt_r == tout_tgt - 1'b1) begin
                  cnt_nxt = '0;
                  state_nxt = ckss_pkg::ST_RUN;
               end
            end
         end
         ckss_pkg::ST_RUN: begin
            if (wr_sleep) begin
               state_nxt = ckss_pkg::ST_SLEEP;
            end
         end
         ckss_pkg::ST_SLEEP: begin
            // New fuse settings take effect at the next wake-up.
            if (rise[ckss_pkg::PIN_WAKE]) begin
               cfg_nxt = fuse_r;
               cnt_nxt = '0;
               state_nxt = ckss_pkg::ST_WAKE;
            end
         end
         ckss_pkg::ST_WAKE: begin
            if (cfg_bad) begin
               state_nxt = ckss_pkg::ST_FAULT;
            end else if (src_rise) begin
               cnt_nxt = cnt_r + 1'b1;
               if (cnt_r == wake_tgt - 1'b1) begin
                  cnt_nxt = '0;
                  state_nxt = ckss_pkg::ST_RUN;
               end
            end
         end
         ckss_pkg::ST_FAULT: begin
            // Sleep stays reachable so a corrected fuse value can be tried.
            if (wr_sleep) begin
               state_nxt = ckss_pkg::ST_SLEEP;
            end
         end
         default: begin
            state_nxt = ckss_pkg::ST_FAULT;
         end
      endcase
   end

   // Only the selected oscillator runs; all stop in power-down.
   always_comb begin
      en_nxt = 3'h0;
      if (state_nxt != ckss_pkg::ST_SLEEP) begin
         en_nxt[0] = (cfg_nxt[ckss_pkg::FUSE_SRC_LSB+1 +: 3] ==
                      ckss_pkg::SRC_LF_PREFIX);
         en_nxt[1] = (cfg_nxt[ckss_pkg::FUSE_SRC_LSB +: 4] ==
                      ckss_pkg::SRC_RC);
         en_nxt[2] = (cfg_nxt[ckss_pkg::FUSE_SRC_LSB +: 4] ==
                      ckss_pkg::SRC_LP);
      end
   end

   always_comb begin
      fuse_nxt = fuse_r;
      trim_nxt = trim_r;
      ack_nxt = wb_req;
      rdat_nxt = 32'h0000_0000;
      if (wr_fuse) begin
         fuse_nxt = wb_dat_i[FW-1:0];
      end
      if (wr_trim) begin
         trim_nxt = wb_dat_i[7:0];
      end
      if (wb_req & ~wb_we_i) begin
         case (wb_adr_i)
            ckss_pkg::OFS_FUSE: rdat_nxt[FW-1:0] = fuse_r;
            ckss_pkg::OFS_TRIM: rdat_nxt[7:0] = trim_r;
            ckss_pkg::OFS_STAT: begin
               rdat_nxt[ckss_pkg::STAT_CFG_LSB +: FW] = cfg_r;
               rdat_nxt[ckss_pkg::STAT_RUN_BIT] = running;
               rdat_nxt[ckss_pkg::STAT_FAULT_BIT] =
                  (state_r == ckss_pkg::ST_FAULT);
               rdat_nxt[ckss_pkg::STAT_SLEEP_BIT] =
                  (state_r == ckss_pkg::ST_SLEEP);
            end
            default: rdat_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_r <= ckss_pkg::ST_TOUT_CK;
         cnt_r <= '0;
         cfg_r <= ckss_pkg::FUSE_RST;
         fuse_r <= ckss_pkg::FUSE_RST;
         trim_r <= factory_trim_i;
         ack_r <= 1'b0;
         rdat_r <= 32'h0000_0000;
         tick_r <= 1'b0;
         en_r <= 3'h2;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         cfg_r <= cfg_nxt;
         fuse_r <= fuse_nxt;
         trim_r <= trim_nxt;
         ack_r <= ack_nxt;
         rdat_r <= rdat_nxt;
         tick_r <= rise[ckss_pkg::PIN_WDT];
         en_r <= en_nxt;
      end
   end

   // The gate only opens once the start-up count is complete.
   ckss_clk_gen u_clk_gen (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .run_i(running),
      .div8_i(cfg_r[ckss_pkg::FUSE_DIV8_BIT]),
      .src_lvl_i(src_lvl),
      .src_rise_i(src_rise),
      .clk_o(sys_clk_o)
   );

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;
   assign rc_trim_o = trim_r;
   assign lf_osc_en_o = en_r[0];
   assign rc_osc_en_o = en_r[1];
   assign lp_osc_en_o = en_r[2];
   assign wdt_tick_o = tick_r;
   assign sys_clk_run_o = running;
endmodule
`default_nettype wire

/* tb/ckss_top_props.sv */
`timescale 1ns/100ps
`default_nettype none
module ckss_top_props (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [7:0] factory_trim_i,
   input wire logic wdt_osc_i,
   input wire logic [7:0] rc_trim_o,
   input wire logic lf_osc_en_o,
   input wire logic rc_osc_en_o,
   input wire logic lp_osc_en_o,
   input wire logic wdt_tick_o,
   input wire logic sys_clk_run_o,
   input wire logic sys_clk_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);

   sequence bus_req_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence trim_wr_s;
      wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ckss_pkg::OFS_TRIM;
   endsequence
   // Three closed cycles leave room for the registered clock to settle.
   sequence gate_shut_s;
      !sys_clk_run_o [*3];
   endsequence

   ack_after_req_a: assert property (bus_req_s |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge longer than one cycle");
   idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data driven outside acknowledge");
   trim_load_a: assert property ($fell(sys_rst_i) |->
         rc_trim_o == factory_trim_i)
      else $error("trim not loaded from factory value");
   trim_write_a: assert property (trim_wr_s |->
         rc_trim_o == wb_dat_i[7:0])
      else $error("trim output does not follow write");
   gate_closed_a: assert property (gate_shut_s |-> !sys_clk_o)
      else $error("system clock toggles while gated");
   one_source_a: assert property (
         $onehot0({lf_osc_en_o, rc_osc_en_o, lp_osc_en_o}))
      else $error("more than one oscillator enabled");
   sleep_gated_a: assert property (
         !(lf_osc_en_o || rc_osc_en_o || lp_osc_en_o) |-> !sys_clk_run_o)
      else $error("clock gate open with no oscillator");
   wdt_tick_a: assert property ($rose(wdt_osc_i) |-> ##[1:8] wdt_tick_o)
      else $error("watchdog edge gave no tick");
endmodule
bind ckss_top ckss_top_props u_ckss_top_props (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .factory_trim_i(factory_trim_i),
   .wdt_osc_i(wdt_osc_i), .rc_trim_o(rc_trim_o),
   .lf_osc_en_o(lf_osc_en_o), .rc_osc_en_o(rc_osc_en_o),
   .lp_osc_en_o(lp_osc_en_o), .wdt_tick_o(wdt_tick_o),
   .sys_clk_run_o(sys_clk_run_o), .sys_clk_o(sys_clk_o)
);
`default_nettype wire

/* tb/clock_source_startup_select_test.sv */
`timescale 1ns/100ps
`default_nettype none
module clock_source_startup_select_test;
   localparam int TLONG = 8;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, wake = 1'b0;
   logic [3:0] adr = 4'h0, sel = 4'h0;
   logic [31:0] dat = 32'h0, rdv;
   logic [31:0] q;
   logic [7:0] ftrim = 8'hA5;
   logic [7:0] trim_o;
   logic lf = 1'b0, rc = 1'b0, lp = 1'b0, wdt = 1'b0;
   logic ack, lf_en, rc_en, lp_en, tick, run, sclk;
   logic src_q = 1'b0, wdt_q = 1'b0, sclk_q = 1'b0;
   logic [2:0] osc_v;
   int tk = 0, src_n = 0, wdt_n = 0, clk_n = 0, src_sel = 1, s0, w0, dn;
   int miscompares = 0, tests_run = 0;
   logic [6:0] cfg_f [4] = '{7'h22, 7'h03, 7'h04, 7'h45};
   int cfg_s [4] = '{1, 2, 0, 0};
   int cfg_n [4] = '{6, 6, 1024, 40};
   logic [6:0] flt_f [3] = '{7'h32, 7'h33, 7'h35};

   assign osc_v = {lp, rc, lf};

   ckss_top #(.WAKE_LF1_CK(40), .TOUT_RC_SHORT(5), .TOUT_RC_LONG(TLONG),
         .TOUT_LP_SHORT(6), .TOUT_LP_LONG(9)) u_ckss_top (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(q), .wb_ack_o(ack), .factory_trim_i(ftrim),
      .lf_osc_i(lf), .rc_osc_i(rc), .lp_osc_i(lp), .wdt_osc_i(wdt),
      .wake_i(wake), .rc_trim_o(trim_o), .lf_osc_en_o(lf_en),
      .rc_osc_en_o(rc_en), .lp_osc_en_o(lp_en), .wdt_tick_o(tick),
      .sys_clk_run_o(run), .sys_clk_o(sclk));

   initial begin
      forever #5 clk_i = ~clk_i;
   end

   // A disabled oscillator holds its level, as a stopped one would.
   always @(posedge clk_i) begin
      tk <= tk + 1;
      if (lf_en && tk % 6 == 0) lf <= !lf;
      if (rc_en && tk % 4 == 0) rc <= !rc;
      if (lp_en && tk % 5 == 0) lp <= !lp;
      if (tk % 7 == 0) wdt <= !wdt;
      src_q <= osc_v[src_sel];
      wdt_q <= wdt;
      sclk_q <= sclk;
      if (osc_v[src_sel] && !src_q) src_n <= src_n + 1;
      if (wdt && !wdt_q) wdt_n <= wdt_n + 1;
      if (sclk && !sclk_q) clk_n <= clk_n + 1;
      if (tk == 40000) begin
         miscompares++;
         conclude();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] s,
         input logic [31:0] d, output logic [31:0] r);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      dat <= d;
      // Only the bench-wide cycle ceiling ends a wait for the answer.
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      r = q;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b1, a, 4'h1, d, rdv);
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 4'hF, 32'h0, rdv);
      check(rdv, e);
   endtask

   task automatic wait_run(input int lim);
      int n;
      n = 0;
      while (run !== 1'b1 && n < lim) begin
         @(posedge clk_i);
         n++;
      end
      check(run, 32'h1);
   endtask

   task automatic cycle_sleep(input logic [6:0] f, input int s);
      wr(ckss_pkg::OFS_FUSE, {25'h0, f});
      wr(ckss_pkg::OFS_CTRL, 32'h1);
      src_sel = s;
      repeat (20) @(posedge clk_i);
      s0 = src_n;
      wake <= 1'b1;
      repeat (8) @(posedge clk_i);
      wake <= 1'b0;
   endtask

   task automatic ratio(input logic d8);
      int a, b;
      a = src_n;
      b = clk_n;
      repeat (600) @(posedge clk_i);
      a = src_n - a;
      b = clk_n - b;
      if (d8) a = a / 8;
      check(b >= a - 1 && b <= a + 1, 32'h1);
   endtask

   task automatic conclude();
      $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
      if (miscompares == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      s0 = src_n;
      rd(ckss_pkg::OFS_FUSE, 32'h62);
      rd(ckss_pkg::OFS_TRIM, 32'hA5);
      rd(4'h2, 32'h0);
      rd(ckss_pkg::OFS_CTRL, 32'h0);
      while (src_n - s0 < 14) @(posedge clk_i);
      repeat (6) @(posedge clk_i);
      check(run, 32'h0);
      w0 = wdt_n;
      wait_run(400);
      check(wdt_n - w0 >= TLONG - 1 && wdt_n - w0 <= TLONG, 32'h1);
      rd(ckss_pkg::OFS_STAT, 32'hE2);
      wr(ckss_pkg::OFS_TRIM, 32'h3C);
      check(trim_o, 32'h3C);
      bus(1'b1, ckss_pkg::OFS_TRIM, 4'h0, 32'hFF, rdv);
      rd(ckss_pkg::OFS_TRIM, 32'h3C);
      for (int i = 0; i < 3; i++) begin
         cycle_sleep(flt_f[i], 1);
         repeat (300) @(posedge clk_i);
         check(run, 32'h0);
         rd(ckss_pkg::OFS_STAT, {23'h0, 2'h2, flt_f[i]});
      end
      // The first pass also leaves the fault state through sleep.
      for (int i = 0; i < 4; i++) begin
         cycle_sleep(cfg_f[i], cfg_s[i]);
         wait_run(14000);
         dn = src_n - s0 - cfg_n[i];
         check(dn >= 0 && dn <= 1, 32'h1);
         check({lp_en, rc_en, lf_en}, 32'h1 << cfg_s[i]);
         rd(ckss_pkg::OFS_STAT, {24'h0, 1'b1, cfg_f[i]});
         ratio(cfg_f[i][6]);
      end
      ftrim <= 8'h5A;
      sys_rst_i <= 1'b1;
      repeat (16) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rd(ckss_pkg::OFS_TRIM, 32'h5A);
      rd(ckss_pkg::OFS_FUSE, 32'h62);
      conclude();
   end
endmodule
`default_nettype wire
